// ==== verilog/bridge_defs.svh ====
// Purpose: constants of the bridge command engine
// Assumes: core clock of 250 MHz
// Notes:   offsets are function codes of the byte after the address
`ifndef BRIDGE_DEFS_SVH
`define BRIDGE_DEFS_SVH
`define FN_CFG 8'hf0
`define FN_CLR_INT 8'hf1
`define FN_IDLE 8'hf2
`define FN_GP_WR 8'hf4
`define FN_GP_RD 8'hf5
`define FN_GP_EN 8'hf6
`define CFG_ORDER_BIT 5
`define CFG_MODE_HI 3
`define CFG_MODE_LO 2
`define CFG_RATE_HI 1
`define CFG_RATE_LO 0
`define GP_EN_RST 4'h0
`define GP_OUT_RST 4'h0
`define BUF_DEPTH 200
`define CLK_KHZ 250000
`define RATE0_KHZ 1843
`define RATE1_KHZ 461
`define RATE2_KHZ 115
`define RATE3_KHZ 58
`define HALF_CYC(k) ((`CLK_KHZ + 2 * (k) - 1) / (2 * (k)))
`endif

// ==== verilog/bridge_pkg.sv ====
// Purpose: types of the bridge command engine
// Assumes: nothing
// Notes:   widths here fit a buffer of at most 255 bytes
package bridge_pkg;
  typedef enum logic [1:0] {
    EV_ADDR  = 2'b00,
    EV_WDATA = 2'b01,
    EV_RDATA = 2'b10,
    EV_STOP  = 2'b11
  } ev_kind_t;
  typedef struct packed {
    ev_kind_t   kind;
    logic [7:0] data;
  } evt_t;
  typedef struct packed {
    logic       order;
    logic [1:0] clock_shape_field;
    logic [1:0] clock_rate_field;
  } spi_cfg_t;
  typedef enum logic [2:0] {
    S_RDY    = 3'b000,
    S_RDWAIT = 3'b001,
    S_LOAD   = 3'b010,
    S_SHIFT  = 3'b011,
    S_SLEEP  = 3'b100
  } core_state_t;
  typedef struct packed {
    core_state_t st;
    logic rq_s1, rq_s2, seen, ack, busy, idle, int_b, have_func;
    logic [7:0] resp, func, param, cnt, ptr, tx, rx;
    spi_cfg_t cfg;
    logic [3:0] gp_en, gp_out, sel, sel_oe, pin_s1, pin_s2;
    logic sclk, mosi, miso_s1, miso_s2;
    logic [11:0] div;
    logic [3:0] edge_n;
    logic [2:0] bi;
  } core_st_t;
  typedef struct packed {
    logic req, ack_s1, ack_s2, busy_s1, busy_s2, rdy;
    evt_t evt;
    logic [7:0] rd_byte;
  } link_st_t;
endpackage

// ==== verilog/msg_buffer.sv ====
// Purpose: message buffer, one write and one registered read port
// Assumes: single clock
// Notes:   contents are not reset
`timescale 1ns/10ps
`default_nettype none
module msg_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 200,
  parameter int AW    = 8
) (
  // clock
  input  wire logic             clk_i,
  // write port
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  // read port
  input  wire logic [AW-1:0]    raddr_i,
  output logic      [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem [DEPTH];
  if (DEPTH > (1 << AW)) begin : g_chk
    $error("msg_buffer depth does not fit address width");
  end
  always_ff @(posedge clk_i) begin
    if (we_i && (int'(waddr_i) < DEPTH)) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= (int'(raddr_i) < DEPTH) ? mem[raddr_i] : '0;
  end
endmodule
`default_nettype wire

// ==== verilog/i2c_to_spi_command_engine.sv ====
// Purpose: command engine of a two-wire slave to serial master bridge
// Assumes: byte events arrive from a slave front end on link_clk_i
// Notes:   one event in flight; busy_o tells the front end to refuse
`include "bridge_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module i2c_to_spi_command_engine #(
  parameter int DEPTH = `BUF_DEPTH
) (
  // core clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // front end side, link clock domain
  input  wire logic              link_clk_i,
  input  wire logic              evt_valid_i,
  input  wire bridge_pkg::evt_t  evt_i,
  output logic                   evt_ready_o,
  output logic [7:0]             rd_byte_o,
  output logic                   busy_o,
  // status
  output logic                   idle_o,
  output logic                   int_b_o,
  // serial master port
  output logic                   serial_clock_out_o,
  output logic                   mosi_o,
  input  wire logic              miso_i,
  // select pins, two-way
  input  wire logic [3:0]        sel_i,
  output logic [3:0]             sel_o,
  output logic [3:0]             sel_oe_o
);
  if (DEPTH < 1 || DEPTH > 255) begin : g_chk
    $error("depth must be 1..255");
  end

  localparam logic [7:0] DEPTH_B = 8'(DEPTH);

  // ===========================================
  // state
  bridge_pkg::core_st_t cs;
  bridge_pkg::core_st_t nxt;
  bridge_pkg::link_st_t lk;
  bridge_pkg::link_st_t lk_nxt;
  logic       lrst_s1;
  logic       lrst_s2;
  logic       link_rst_b;
  logic       new_ev;
  logic       mem_we;
  logic [7:0] mem_wa;
  logic [7:0] mem_wd;
  logic [7:0] mem_ra;
  logic [7:0] mem_rd;
  logic [11:0] half_m1;
  logic       trail;
  logic       cap;
  logic [2:0] pos;
  logic       is_xfer;

  assign link_rst_b = lrst_s2;
  // event data is stable while the request toggle is pending
  assign new_ev = cs.rq_s2 != cs.seen;
  assign trail = cs.cfg.clock_shape_field[1] ^ cs.cfg.clock_shape_field[0];
  assign is_xfer = (cs.func[7:4] == 4'h0) && (cs.func[3:0] != 4'h0);

  // ===========================================
  // buffer
  msg_buffer #(
    .WIDTH (8),
    .DEPTH (DEPTH),
    .AW    (8)
  ) u_buf (
    .clk_i   (clk_i),
    .we_i    (mem_we),
    .waddr_i (mem_wa),
    .wdata_i (mem_wd),
    .raddr_i (mem_ra),
    .rdata_o (mem_rd)
  );

  // ===========================================
  // rate select
  always_comb begin
    case (cs.cfg.clock_rate_field)
      2'b00:   half_m1 = 12'(`HALF_CYC(`RATE0_KHZ) - 1);
      2'b01:   half_m1 = 12'(`HALF_CYC(`RATE1_KHZ) - 1);
      2'b10:   half_m1 = 12'(`HALF_CYC(`RATE2_KHZ) - 1);
      default: half_m1 = 12'(`HALF_CYC(`RATE3_KHZ) - 1);
    endcase
  end

  // ===========================================
  // core next state
  always_comb begin
    nxt = cs;
    mem_we = 1'b0;
    mem_wa = 8'h00;
    mem_wd = 8'h00;
    mem_ra = cs.ptr;
    cap = 1'b0;
    pos = cs.cfg.order ? cs.bi : ~cs.bi;
    nxt.rq_s1 = lk.req;
    nxt.rq_s2 = cs.rq_s1;
    nxt.miso_s1 = miso_i;
    nxt.miso_s2 = cs.miso_s1;
    nxt.pin_s1 = sel_i;
    nxt.pin_s2 = cs.pin_s1;
    case (cs.st)
      bridge_pkg::S_RDY, bridge_pkg::S_SLEEP: begin
        if (new_ev) begin
          nxt.seen = cs.rq_s2;
          nxt.ack = ~cs.ack;
          // asleep, only an address is taken; anything else is dropped
          if (cs.st == bridge_pkg::S_RDY || lk.evt.kind == bridge_pkg::EV_ADDR) begin
            case (lk.evt.kind)
              bridge_pkg::EV_ADDR: begin
                nxt.idle = 1'b0;
                nxt.st = bridge_pkg::S_RDY;
                nxt.have_func = 1'b0;
                if (lk.evt.data[0]) begin
                  nxt.ptr = 8'h00;
                  mem_ra = 8'h00;
                  nxt.ack = cs.ack;
                  nxt.st = bridge_pkg::S_RDWAIT;
                end else begin
                  nxt.cnt = 8'h00;
                end
              end
              bridge_pkg::EV_WDATA: begin
                if (!cs.have_func) begin
                  nxt.func = lk.evt.data;
                  nxt.have_func = 1'b1;
                end else if (cs.cnt < DEPTH_B) begin
                  mem_we = 1'b1;
                  mem_wa = cs.cnt;
                  mem_wd = lk.evt.data;
                  if (cs.cnt == 8'h00) begin
                    nxt.param = lk.evt.data;
                  end
                  nxt.cnt = 8'(cs.cnt + 8'h01);
                end
              end
              bridge_pkg::EV_RDATA: begin
                nxt.ack = cs.ack;
                if (cs.ptr < 8'(DEPTH_B - 8'h01)) begin
                  nxt.ptr = 8'(cs.ptr + 8'h01);
                end
                mem_ra = nxt.ptr;
                nxt.st = bridge_pkg::S_RDWAIT;
              end
              default: begin
                nxt.have_func = 1'b0;
                if (cs.have_func) begin
                  if (is_xfer) begin
                    if (cs.cnt != 8'h00) begin
                      nxt.busy = 1'b1;
                      nxt.ptr = 8'h00;
                      mem_ra = 8'h00;
                      nxt.st = bridge_pkg::S_LOAD;
                    end
                  end else begin
                    case (cs.func)
                      `FN_CFG: begin
                        if (cs.cnt != 8'h00) begin
                          nxt.cfg.order = cs.param[`CFG_ORDER_BIT];
                          nxt.cfg.clock_shape_field = cs.param[`CFG_MODE_HI:`CFG_MODE_LO];
                          nxt.cfg.clock_rate_field = cs.param[`CFG_RATE_HI:`CFG_RATE_LO];
                        end
                      end
                      `FN_CLR_INT: nxt.int_b = 1'b1;
                      `FN_IDLE: begin
                        nxt.idle = 1'b1;
                        nxt.st = bridge_pkg::S_SLEEP;
                      end
                      `FN_GP_WR: begin
                        if (cs.cnt != 8'h00) begin
                          nxt.gp_out = cs.param[3:0];
                        end
                      end
                      `FN_GP_RD: begin
                        // select-duty pins give their pin level, which has no meaning
                        mem_we = 1'b1;
                        mem_wa = 8'h00;
                        mem_wd = {4'h0, cs.pin_s2};
                      end
                      `FN_GP_EN: begin
                        if (cs.cnt != 8'h00) begin
                          nxt.gp_en = cs.param[3:0];
                        end
                      end
                      default: ;
                    endcase
                  end
                end
              end
            endcase
          end
        end
      end
      bridge_pkg::S_RDWAIT: begin
        nxt.resp = mem_rd;
        nxt.ack = ~cs.ack;
        nxt.st = bridge_pkg::S_RDY;
      end
      bridge_pkg::S_LOAD: begin
        nxt.tx = mem_rd;
        nxt.rx = 8'h00;
        nxt.bi = 3'h0;
        nxt.edge_n = 4'h0;
        nxt.div = 12'h000;
        nxt.st = bridge_pkg::S_SHIFT;
      end
      bridge_pkg::S_SHIFT: begin
        if (cs.div == half_m1) begin
          nxt.div = 12'h000;
          nxt.sclk = ~cs.sclk;
          cap = (~cs.edge_n[0]) ^ trail;
          if (cap) begin
            nxt.rx[pos] = cs.miso_s2;
          end else if (!(trail && cs.edge_n == 4'h0)) begin
            nxt.bi = 3'(cs.bi + 3'h1);
          end
          nxt.edge_n = 4'(cs.edge_n + 4'h1);
          if (cs.edge_n == 4'hf) begin
            mem_we = 1'b1;
            mem_wa = cs.ptr;
            mem_wd = nxt.rx;
            if (8'(cs.ptr + 8'h01) == cs.cnt) begin
              nxt.busy = 1'b0;
              nxt.int_b = 1'b0;
              nxt.st = bridge_pkg::S_RDY;
            end else begin
              nxt.ptr = 8'(cs.ptr + 8'h01);
              mem_ra = nxt.ptr;
              nxt.st = bridge_pkg::S_LOAD;
            end
          end
        end else begin
          nxt.div = 12'(cs.div + 12'h001);
        end
      end
      default: nxt.st = bridge_pkg::S_RDY;
    endcase
    nxt.mosi = nxt.tx[nxt.cfg.order ? nxt.bi : ~nxt.bi];
    if (!nxt.busy) begin
      nxt.sclk = nxt.cfg.clock_shape_field[1];
    end
    for (int i = 0; i < 4; i++) begin
      if (nxt.gp_en[i]) begin
        // quasi-bidirectional: strong low, high left to the weak pull-up
        nxt.sel[i] = nxt.gp_out[i];
        nxt.sel_oe[i] = ~nxt.gp_out[i];
      end else begin
        nxt.sel[i] = ~(nxt.busy & nxt.func[i]);
        nxt.sel_oe[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cs <= '0;
      cs.int_b <= 1'b1;
      cs.gp_en <= `GP_EN_RST;
      cs.gp_out <= `GP_OUT_RST;
      cs.sel <= 4'hf;
      cs.sel_oe <= 4'hf;
    end else begin
      cs <= nxt;
    end
  end

  // ===========================================
  // link domain
  always_ff @(posedge link_clk_i) begin
    lrst_s1 <= rst_b_i;
    lrst_s2 <= lrst_s1;
  end

  always_comb begin
    lk_nxt = lk;
    lk_nxt.ack_s1 = cs.ack;
    lk_nxt.ack_s2 = lk.ack_s1;
    lk_nxt.busy_s1 = cs.busy;
    lk_nxt.busy_s2 = lk.busy_s1;
    if (evt_valid_i && lk.req == lk.ack_s2) begin
      lk_nxt.evt = evt_i;
      lk_nxt.req = ~lk.req;
    end
    lk_nxt.rdy = lk_nxt.req == lk.ack_s2;
    if (lk.req == lk.ack_s2) begin
      lk_nxt.rd_byte = cs.resp;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (!link_rst_b) begin
      lk <= '0;
    end else begin
      lk <= lk_nxt;
    end
  end

  assign evt_ready_o = lk.rdy;
  assign rd_byte_o = lk.rd_byte;
  assign busy_o = lk.busy_s2;
  assign idle_o = cs.idle;
  assign int_b_o = cs.int_b;
  assign serial_clock_out_o = cs.sclk;
  assign mosi_o = cs.mosi;
  assign sel_o = cs.sel;
  assign sel_oe_o = cs.sel_oe;

  // ===========================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  logic stop_ev;
  assign stop_ev = (cs.st == bridge_pkg::S_RDY) && new_ev && cs.have_func &&
                   (lk.evt.kind == bridge_pkg::EV_STOP);

  chk_int_done: assert property ($fell(cs.busy) |-> !int_b_o)
    else $error("interrupt not raised at transfer end");
  chk_int_clear: assert property ((stop_ev && cs.func == `FN_CLR_INT) |=> int_b_o)
    else $error("interrupt not released");
  chk_sel_release: assert property ($fell(cs.busy) |-> &(sel_o | cs.gp_en))
    else $error("select still low after transfer");
  chk_sel_active: assert property ((cs.st == bridge_pkg::S_SHIFT) |->
    ((sel_o | cs.gp_en) == (~cs.func[3:0] | cs.gp_en)))
    else $error("wrong selects during transfer");
  chk_clock_idle: assert property ((cs.st == bridge_pkg::S_RDY) |->
    serial_clock_out_o == cs.cfg.clock_shape_field[1])
    else $error("serial clock not at idle level");
  chk_edge_timing: assert property ((cs.st == bridge_pkg::S_SHIFT && $changed(cs.sclk))
    |-> cs.div == 12'h000 && $past(cs.div) == half_m1)
    else $error("serial clock edge off the divider");
  chk_byte_count: assert property ($fell(cs.busy) |-> 8'(cs.ptr + 8'h01) == cs.cnt)
    else $error("byte count mismatch");
  chk_read_clean: assert property ((cs.st == bridge_pkg::S_RDWAIT) |-> !mem_we
    ##1 cs.st == bridge_pkg::S_RDY)
    else $error("read disturbed the buffer");
  chk_sleep_entry: assert property ((stop_ev && cs.func == `FN_IDLE) |=> idle_o
    && cs.st == bridge_pkg::S_SLEEP)
    else $error("idle not entered");
  chk_wake_addr: assert property ((cs.st == bridge_pkg::S_SLEEP && new_ev &&
    lk.evt.kind == bridge_pkg::EV_ADDR) |=> !idle_o)
    else $error("no wake on address");
  chk_gpio_reset: assert property ($rose(rst_b_i) |-> cs.gp_en == 4'h0)
    else $error("pins not on select duty after reset");
  chk_busy_link: assert property (@(posedge link_clk_i) disable iff (!link_rst_b)
    (evt_valid_i && evt_ready_o) |=> !evt_ready_o)
    else $error("event accepted while one pending");

  cov_xfer: cover property ($fell(cs.busy));
  cov_read: cover property (cs.st == bridge_pkg::S_RDWAIT);
  cov_sleep: cover property (cs.st == bridge_pkg::S_SLEEP ##1 !idle_o);
endmodule
`default_nettype wire

// ==== testbench/spi_slave_model.sv ====
// Purpose: serial slave that answers 50h plus byte index in each frame
// Assumes: shape and order inputs are set to match the engine setup
// Notes:   outside a frame miso flips so a stale bit is never sampled
`timescale 1ns/10ps
`default_nettype none
module spi_slave_model (
  // serial port
  input  wire logic       sclk_i,
  input  wire logic       mosi_i,
  input  wire logic [3:0] sel_i,
  // shape of the frame
  input  wire logic       idle_i,
  input  wire logic       trail_i,
  input  wire logic       lsb_i,
  output logic            miso_o
);
  logic [7:0] rx_q [$];
  logic [7:0] sh;
  int         bitn;
  int         byten;
  logic       act_q;
  logic       sclk_q;
  wire logic  act;

  assign act = ~&sel_i;

  function automatic logic pick();
    logic [7:0] b;
    b = 8'h50 + 8'(byten);
    return lsb_i ? b[bitn] : b[7-bitn];
  endfunction

  // one process owns miso; it looks 1 ns after a change so that a select
  // release in the step of the last clock edge is taken after that edge
  initial begin
    miso_o = 1'b0;
    act_q = 1'b0;
    sclk_q = 1'b0;
    bitn = 0;
    byten = 0;
    forever begin
      @(act or sclk_i);
      #1;
      // capture when the edge kind differs from the trailing flag
      if (act_q && (sclk_i !== sclk_q)) begin
        if ((sclk_i != idle_i) != trail_i) begin
          sh = lsb_i ? {mosi_i, sh[7:1]} : {sh[6:0], mosi_i};
          bitn++;
          if (bitn == 8) begin
            rx_q.push_back(sh);
            bitn = 0;
            byten++;
          end
        end else begin
          miso_o = pick();
        end
      end
      sclk_q = sclk_i;
      if (act !== act_q) begin
        act_q = act;
        bitn = 0;
        byten = 0;
        if (act && !trail_i) begin
          miso_o = pick();
        end
        if (!act) begin
          miso_o = ~miso_o;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Purpose: self-checking bench of the bridge command engine
// Assumes: front end events are offered on the link clock
// Notes:   the slowest rate dominates the run time
`include "bridge_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam int LIMIT = 90000;
  logic             clk_i, rst_b_i, link_clk, evt_valid_i;
  logic             idle_m, trail_m, lsb_m, miso;
  bridge_pkg::evt_t evt_i;
  logic             evt_ready_o, busy_o, idle_o, int_b_o, sclk, mosi;
  logic [7:0]       rd_byte_o;
  logic [3:0]       sel_o, sel_oe_o;
  wire logic [3:0]  pin;
  int               bad_count = 0;
  int               compares = 0;
  int               cyc = 0;
  int               tog = 0;
  int               t_prev = 0;
  int               t_last = 0;
  logic             sclk_q;
  int               half_t [4] = '{68, 272, 1087, 2156};
  // several selects at once are safe here: one model slave drives miso
  logic [3:0]       pick_t [4] = '{4'h1, 4'h6, 4'h8, 4'hf};

  // released pins float up through the weak pull-up
  assign pin = sel_o | ~sel_oe_o;

  i2c_to_spi_command_engine dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .link_clk_i(link_clk),
    .evt_valid_i(evt_valid_i), .evt_i(evt_i), .evt_ready_o(evt_ready_o),
    .rd_byte_o(rd_byte_o), .busy_o(busy_o), .idle_o(idle_o), .int_b_o(int_b_o),
    .serial_clock_out_o(sclk), .mosi_o(mosi), .miso_i(miso),
    .sel_i(pin), .sel_o(sel_o), .sel_oe_o(sel_oe_o)
  );

  spi_slave_model slave (
    .sclk_i(sclk), .mosi_i(mosi), .sel_i(pin), .idle_i(idle_m),
    .trail_i(trail_m), .lsb_i(lsb_m), .miso_o(miso)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    link_clk = 1'b0;
    #13;
    forever #40 link_clk = ~link_clk;
  end

  // edge times are taken one cycle late, which cancels in differences
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    sclk_q <= sclk;
    if (sclk !== sclk_q) begin
      tog <= tog + 1;
      t_prev <= t_last;
      t_last <= cyc;
    end
    if (cyc == LIMIT) begin
      bad_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_ready();
    do begin
      @(negedge link_clk);
    end while (evt_ready_o !== 1'b1);
  endtask

  task automatic send(input bridge_pkg::ev_kind_t k, input logic [7:0] d);
    wait_ready();
    @(posedge link_clk);
    evt_valid_i <= 1'b1;
    evt_i <= '{kind: k, data: d};
    @(posedge link_clk);
    evt_valid_i <= 1'b0;
    wait_ready();
  endtask

  task automatic write_msg(input logic [7:0] f, input int n, input logic [23:0] pl);
    send(bridge_pkg::EV_ADDR, 8'h00);
    send(bridge_pkg::EV_WDATA, f);
    for (int i = 0; i < n; i++) begin
      send(bridge_pkg::EV_WDATA, pl[23-8*i -: 8]);
    end
    send(bridge_pkg::EV_STOP, 8'h00);
  endtask

  task automatic read_buf(input int n, output logic [15:0] got);
    send(bridge_pkg::EV_ADDR, 8'h01);
    got = {8'h00, rd_byte_o};
    if (n > 1) begin
      send(bridge_pkg::EV_RDATA, 8'h00);
      got = {got[7:0], rd_byte_o};
    end
    send(bridge_pkg::EV_STOP, 8'h00);
  endtask

  task automatic finish_xfer(output logic [3:0] mid);
    int t0;
    t0 = tog;
    while (tog == t0) begin
      @(negedge clk_i);
    end
    mid = sel_o;
    while (busy_o !== 1'b0) begin
      @(negedge link_clk);
    end
    @(negedge clk_i);
  endtask

  initial begin
    logic [7:0]  cfg;
    logic [3:0]  mid;
    logic [15:0] got;
    int          t0;
    rst_b_i = 1'b0;
    evt_valid_i = 1'b0;
    evt_i = '0;
    idle_m = 1'b0;
    trail_m = 1'b0;
    lsb_m = 1'b0;
    // link side needs three of its own edges in reset
    repeat (6) @(posedge link_clk);
    @(negedge clk_i);
    check({12'h000, sel_o}, 16'h000f);
    check({12'h000, sel_oe_o}, 16'h000f);
    check({14'h0000, int_b_o, idle_o}, 16'h0002);
    @(posedge clk_i);
    rst_b_i <= 1'b1;
    $display("test reset done");

    t0 = tog;
    write_msg(8'h01, 2, 24'ha53c00);
    check({15'h0000, busy_o}, 16'h0001);
    finish_xfer(mid);
    check({12'h000, mid}, 16'h000e);
    check({12'h000, sel_o}, 16'h000f);
    check({15'h0000, int_b_o}, 16'h0000);
    check(16'(slave.rx_q.size()), 16'h0002);
    check({slave.rx_q[0], slave.rx_q[1]}, 16'ha53c);
    check(16'(tog - t0), 16'h0020);
    read_buf(2, got);
    check(got, 16'h5051);
    read_buf(2, got);
    check(got, 16'h5051);
    $display("test transfer done");

    write_msg(`FN_CLR_INT, 0, 24'h000000);
    @(negedge clk_i);
    check({15'h0000, int_b_o}, 16'h0001);
    $display("test clear done");

    for (int m = 0; m < 4; m++) begin
      cfg = {2'h0, m[0], 1'h0, m[1:0], m[1:0]};
      write_msg(`FN_CFG, 1, {cfg, 16'h0000});
      idle_m = m[1];
      trail_m = m[1] ^ m[0];
      lsb_m = m[0];
      slave.rx_q.delete();
      t0 = tog;
      write_msg({4'h0, pick_t[m]}, 1, {8'hc5 ^ 8'(m), 16'h0000});
      finish_xfer(mid);
      check({12'h000, mid}, {12'h000, ~pick_t[m]});
      check(16'(slave.rx_q[0]), {8'h00, 8'hc5 ^ 8'(m)});
      check(16'(t_last - t_prev), 16'(half_t[m]));
      check(16'(tog - t0), 16'h0010);
      check({15'h0000, sclk}, {15'h0000, m[1]});
      read_buf(1, got);
      check(got, 16'h0050);
    end
    $display("test shapes done");

    write_msg(`FN_GP_EN, 1, 24'h030000);
    write_msg(`FN_GP_WR, 1, 24'h020000);
    @(negedge clk_i);
    check({12'h000, sel_oe_o}, 16'h000d);
    check({12'h000, sel_o & 4'hd}, 16'h000c);
    write_msg(`FN_GP_RD, 0, 24'h000000);
    read_buf(1, got);
    check(got & 16'h00f3, 16'h0002);
    write_msg(`FN_GP_EN, 1, 24'h000000);
    @(negedge clk_i);
    check({8'h00, sel_oe_o, sel_o}, 16'h00ff);
    $display("test pins done");

    write_msg(`FN_IDLE, 0, 24'h000000);
    @(negedge clk_i);
    check({15'h0000, idle_o}, 16'h0001);
    send(bridge_pkg::EV_ADDR, 8'h00);
    @(negedge clk_i);
    check({15'h0000, idle_o}, 16'h0000);
    send(bridge_pkg::EV_STOP, 8'h00);
    $display("test idle done");
    close_out();
  end
endmodule
`default_nettype wire
